// ### ipsig_pkg.sv
// Package: constants and types for the interrupt pin signalling block
package ipsig_pkg;

  // ----------------------------------------------------------------
  // Service table positions (interrupt numbers)
  // ----------------------------------------------------------------
  localparam logic [3:0] IPSIG_NUM_RESET = 4'h0;
  localparam logic [3:0] IPSIG_NUM_NMI = 4'h1;
  localparam logic [3:0] IPSIG_NUM_EXT4 = 4'h4;
  localparam logic [3:0] IPSIG_NUM_EXT5 = 4'h5;
  localparam logic [3:0] IPSIG_NUM_EXT6 = 4'h6;
  localparam logic [3:0] IPSIG_NUM_EXT7 = 4'h7;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] IPSIG_NUM_RST = 4'h0;
  localparam logic [15:0] IPSIG_PEND_RST = 16'h0000;
  localparam logic [4:0] IPSIG_PIN_RST = 5'h00;
  localparam int IPSIG_PINS = 5;
  localparam int IPSIG_SOURCES = 16;

  // ----------------------------------------------------------------
  // Acknowledge sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IPSIG_IDLE = 2'b01,
    IPSIG_ACK = 2'b10
  } ipsig_state_t;

endpackage : ipsig_pkg

// ### ipsig_edge.sv
// Module: two-flop synchroniser with rising edge detector for the interrupt pins
`timescale 1ns/1ps
module ipsig_edge (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Asynchronous pins
  input wire logic [ipsig_pkg::IPSIG_PINS-1:0] pin_async,
  // Rising edge pulses
  output logic [ipsig_pkg::IPSIG_PINS-1:0] rise
);

  logic [ipsig_pkg::IPSIG_PINS-1:0] meta;
  logic [ipsig_pkg::IPSIG_PINS-1:0] sync;
  logic [ipsig_pkg::IPSIG_PINS-1:0] prev;
  wire [ipsig_pkg::IPSIG_PINS-1:0] next_rise;

  assign next_rise = sync & ~prev;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta <= ipsig_pkg::IPSIG_PIN_RST;
      sync <= ipsig_pkg::IPSIG_PIN_RST;
      prev <= ipsig_pkg::IPSIG_PIN_RST;
      rise <= ipsig_pkg::IPSIG_PIN_RST;
    end else begin
      meta <= pin_async;
      sync <= meta;
      prev <= sync;
      rise <= next_rise;
    end
  end

endmodule : ipsig_edge

// ### ipsig_top.sv
// Module: interrupt pin signalling, edge capture and acknowledge/number outputs
//
// What this block does
// - Pins request only on rising edges
// - Acknowledge pulses when servicing any interrupt
// - Four-line number names serviced interrupt
// - Number valid during acknowledge, internal too
// - Number equals service table position
`timescale 1ns/1ps
module ipsig_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Interrupt pins
  input wire logic nmi_in,
  input wire logic external_interrupt_line_4,
  input wire logic external_interrupt_line_5,
  input wire logic external_interrupt_line_6,
  input wire logic external_interrupt_line_7,
  // Internal peripheral requests, one-cycle pulses, indexed by table position
  input wire logic [15:0] internal_request,
  // CPU service handshake
  input wire logic service_start,
  // Pending sources toward the CPU
  output logic [15:0] pending,
  // Acknowledge and number
  output logic interrupt_acknowledge_out,
  output logic active_interrupt_number_bit3,
  output logic active_interrupt_number_bit2,
  output logic active_interrupt_number_bit1,
  output logic active_interrupt_number_bit0
);

  // ------------------------------------------------------------
  // Shared decoders
  // ------------------------------------------------------------
  // One-hot mask of a service table position
  function automatic logic [15:0] ipsig_bit(input logic [3:0] pos);
    logic [15:0] mask;
    case (pos)
      4'h0: mask = 16'h0001;
      4'h1: mask = 16'h0002;
      4'h2: mask = 16'h0004;
      4'h3: mask = 16'h0008;
      4'h4: mask = 16'h0010;
      4'h5: mask = 16'h0020;
      4'h6: mask = 16'h0040;
      4'h7: mask = 16'h0080;
      4'h8: mask = 16'h0100;
      4'h9: mask = 16'h0200;
      4'hA: mask = 16'h0400;
      4'hB: mask = 16'h0800;
      4'hC: mask = 16'h1000;
      4'hD: mask = 16'h2000;
      4'hE: mask = 16'h4000;
      4'hF: mask = 16'h8000;
      default: mask = 16'h0000;
    endcase
    return mask;
  endfunction : ipsig_bit

  // Lowest pending position, position 0 first
  function automatic logic [3:0] ipsig_first(input logic [15:0] req);
    logic [3:0] idx;
    if (req[0]) begin
      idx = 4'h0;
    end else if (req[1]) begin
      idx = 4'h1;
    end else if (req[2]) begin
      idx = 4'h2;
    end else if (req[3]) begin
      idx = 4'h3;
    end else if (req[4]) begin
      idx = 4'h4;
    end else if (req[5]) begin
      idx = 4'h5;
    end else if (req[6]) begin
      idx = 4'h6;
    end else if (req[7]) begin
      idx = 4'h7;
    end else if (req[8]) begin
      idx = 4'h8;
    end else if (req[9]) begin
      idx = 4'h9;
    end else if (req[10]) begin
      idx = 4'hA;
    end else if (req[11]) begin
      idx = 4'hB;
    end else if (req[12]) begin
      idx = 4'hC;
    end else if (req[13]) begin
      idx = 4'hD;
    end else if (req[14]) begin
      idx = 4'hE;
    end else if (req[15]) begin
      idx = 4'hF;
    end else begin
      idx = ipsig_pkg::IPSIG_NUM_RST;
    end
    return idx;
  endfunction : ipsig_first

  // ------------------------------------------------------------
  // Pin edge capture
  // ------------------------------------------------------------
  wire [ipsig_pkg::IPSIG_PINS-1:0] pin_vec;
  wire [ipsig_pkg::IPSIG_PINS-1:0] pin_rise;

  assign pin_vec = {external_interrupt_line_7, external_interrupt_line_6, external_interrupt_line_5,
                    external_interrupt_line_4, nmi_in};

  ipsig_edge u_edge (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_async(pin_vec),
    .rise(pin_rise)
  );

  // ------------------------------------------------------------
  // Pin requests at their table positions
  // ------------------------------------------------------------
  wire [15:0] nmi_req;
  wire [15:0] ext4_req;
  wire [15:0] ext5_req;
  wire [15:0] ext6_req;
  wire [15:0] ext7_req;
  wire [15:0] pin_req;

  assign nmi_req = ipsig_bit(ipsig_pkg::IPSIG_NUM_NMI) & {16{pin_rise[0]}};
  assign ext4_req = ipsig_bit(ipsig_pkg::IPSIG_NUM_EXT4) & {16{pin_rise[1]}};
  assign ext5_req = ipsig_bit(ipsig_pkg::IPSIG_NUM_EXT5) & {16{pin_rise[2]}};
  assign ext6_req = ipsig_bit(ipsig_pkg::IPSIG_NUM_EXT6) & {16{pin_rise[3]}};
  assign ext7_req = ipsig_bit(ipsig_pkg::IPSIG_NUM_EXT7) & {16{pin_rise[4]}};
  assign pin_req = nmi_req | ext4_req | ext5_req | ext6_req | ext7_req;

  // ------------------------------------------------------------
  // Service selection
  // ------------------------------------------------------------
  wire [15:0] new_req;
  wire any_pending;
  wire take;
  wire [3:0] next_num;
  wire [15:0] serviced_bit;

  assign new_req = pin_req | internal_request;
  assign any_pending = |pending;
  assign take = service_start & any_pending;
  assign next_num = ipsig_first(pending);
  assign serviced_bit = take ? ipsig_bit(next_num) : ipsig_pkg::IPSIG_PEND_RST;

  // ------------------------------------------------------------
  // Pending set
  // ------------------------------------------------------------
  wire [15:0] next_pending;

  // New request wins over the service clear
  assign next_pending = (pending & ~serviced_bit) | new_req;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pending <= ipsig_pkg::IPSIG_PEND_RST;
    end else begin
      pending <= next_pending;
    end
  end

  // ------------------------------------------------------------
  // Acknowledge sequencer
  // ------------------------------------------------------------
  ipsig_pkg::ipsig_state_t state;
  ipsig_pkg::ipsig_state_t next_state;
  wire next_ack;

  always_comb begin
    case (state)
      ipsig_pkg::IPSIG_IDLE: next_state = take ? ipsig_pkg::IPSIG_ACK : ipsig_pkg::IPSIG_IDLE;
      ipsig_pkg::IPSIG_ACK: next_state = take ? ipsig_pkg::IPSIG_ACK : ipsig_pkg::IPSIG_IDLE;
      default: next_state = ipsig_pkg::IPSIG_IDLE;
    endcase
  end

  assign next_ack = (next_state == ipsig_pkg::IPSIG_ACK);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= ipsig_pkg::IPSIG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Acknowledge output
  // ------------------------------------------------------------
  // One acknowledge cycle per serviced interrupt, pins and internal alike
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      interrupt_acknowledge_out <= 1'h0;
    end else begin
      interrupt_acknowledge_out <= next_ack;
    end
  end

  // ------------------------------------------------------------
  // Interrupt number
  // ------------------------------------------------------------
  logic [3:0] num;

  // Loaded with each take, held until the next
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      num <= ipsig_pkg::IPSIG_NUM_RST;
    end else if (take) begin
      num <= next_num;
    end
  end

  assign active_interrupt_number_bit3 = num[3];
  assign active_interrupt_number_bit2 = num[2];
  assign active_interrupt_number_bit1 = num[1];
  assign active_interrupt_number_bit0 = num[0];

endmodule : ipsig_top

// ### ipsig_props.sv
// Checker: assertions on the interrupt pin signalling ports
`timescale 1ns/1ps
module ipsig_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Interrupt pins
  input wire logic nmi_in,
  input wire logic external_interrupt_line_4,
  input wire logic external_interrupt_line_5,
  input wire logic external_interrupt_line_6,
  input wire logic external_interrupt_line_7,
  // Internal requests and CPU service
  input wire logic [15:0] internal_request,
  input wire logic service_start,
  // Pending, acknowledge and number
  input wire logic [15:0] pending,
  input wire logic interrupt_acknowledge_out,
  input wire logic active_interrupt_number_bit3,
  input wire logic active_interrupt_number_bit2,
  input wire logic active_interrupt_number_bit1,
  input wire logic active_interrupt_number_bit0
);
  wire ack = interrupt_acknowledge_out;
  wire [3:0] num = {active_interrupt_number_bit3, active_interrupt_number_bit2,
    active_interrupt_number_bit1, active_interrupt_number_bit0};
  logic [15:0] lp;
  always_ff @(posedge sys_clk) lp <= pending;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  property pin_edge_p(logic p, int b);
    $rose(pending[b]) |-> $past(internal_request[b]) || $past(p, 3) && !$past(p, 4) || $past(p, 4) && !$past(p, 5);
  endproperty
  ack_cause_a: assert property (ack |-> $past(service_start) && lp != 16'h0)
    else $error("ack without a take");
  ack_taken_a: assert property (service_start && pending != 16'h0 |=> ack)
    else $error("take without ack");
  num_lowest_a: assert property (ack |-> lp[num] && (lp & ((16'h1 << num) - 16'h1)) == 16'h0)
    else $error("number not lowest pending");
  num_held_a: assert property (!ack |-> $stable(num))
    else $error("number moved without ack");
  clear_by_ack_a: assert property ((lp & ~pending) != 16'h0 |-> ack && (lp & ~pending) == (16'h1 << num))
    else $error("pending cleared wrongly");
  nmi_edge_a: assert property (pin_edge_p(nmi_in, 1))
    else $error("nmi pending without edge");
  ext_edge_a: assert property (pin_edge_p(external_interrupt_line_5, 5))
    else $error("line 5 pending without edge");
  ext4_edge_a: assert property (pin_edge_p(external_interrupt_line_4, 4))
    else $error("line 4 pending without edge");
  ext6_edge_a: assert property (pin_edge_p(external_interrupt_line_6, 6))
    else $error("line 6 pending without edge");
  ext7_edge_a: assert property (pin_edge_p(external_interrupt_line_7, 7))
    else $error("line 7 pending without edge");
  cover property (ack && num == 4'h1);
  cover property (ack && num == 4'h7);
  cover property (ack ##1 ack);
endmodule : ipsig_props
bind ipsig_top ipsig_props i_props (
  .sys_clk(sys_clk),
  .reset(reset),
  .nmi_in(nmi_in),
  .external_interrupt_line_4(external_interrupt_line_4),
  .external_interrupt_line_5(external_interrupt_line_5),
  .external_interrupt_line_6(external_interrupt_line_6),
  .external_interrupt_line_7(external_interrupt_line_7),
  .internal_request(internal_request),
  .service_start(service_start),
  .pending(pending),
  .interrupt_acknowledge_out(interrupt_acknowledge_out),
  .active_interrupt_number_bit3(active_interrupt_number_bit3),
  .active_interrupt_number_bit2(active_interrupt_number_bit2),
  .active_interrupt_number_bit1(active_interrupt_number_bit1),
  .active_interrupt_number_bit0(active_interrupt_number_bit0)
);

// ### ipsig_src.sv
// Model: external interrupt sources on the nmi and external pins
`timescale 1ns/1ps
module ipsig_src (
  // Clock
  input wire logic sys_clk,
  // Pins: nmi at bit 0, then lines 4 to 7
  output logic [4:0] pins
);
  initial pins = 5'h00;
  // Raise masked pins, hold n cycles, drop at a falling edge
  task automatic pulse(input logic [4:0] m, input int n);
    pins = pins | m;
    repeat (n) @(negedge sys_clk);
    pins = pins & ~m;
  endtask : pulse
endmodule : ipsig_src

// ### tb_top.sv
// Testbench: drives pins, internal requests and service, checks ack and number
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, reset, service_start, ack;
  logic [15:0] internal_request, pending;
  logic [4:0] pins;
  logic [3:0] num;
  int n_errors = 0;
  int samples_checked = 0;
  ipsig_src i_src (.sys_clk(sys_clk), .pins(pins));
  ipsig_top i_dut (.sys_clk(sys_clk), .reset(reset), .nmi_in(pins[0]), .external_interrupt_line_4(pins[1]),
    .external_interrupt_line_5(pins[2]), .external_interrupt_line_6(pins[3]), .external_interrupt_line_7(pins[4]),
    .internal_request(internal_request), .service_start(service_start), .pending(pending),
    .interrupt_acknowledge_out(ack), .active_interrupt_number_bit3(num[3]), .active_interrupt_number_bit2(num[2]),
    .active_interrupt_number_bit1(num[1]), .active_interrupt_number_bit0(num[0]));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Back-to-back takes, one ack and number per cycle
  task automatic serve(input logic [3:0] q[$]);
    service_start = 1'b1;
    foreach (q[i]) begin
      @(negedge sys_clk);
      if (i == q.size() - 1) service_start = 1'b0;
      chk("ack", 16'h1, {15'h0, ack});
      chk("number", {12'h0, q[i]}, {12'h0, num});
    end
  endtask : serve
  task automatic t_edge;
    fork
      i_src.pulse(5'h01, 16);
      begin
        repeat (6) @(negedge sys_clk);
        chk("pending", 16'h0002, pending);
        serve('{4'h1});
        repeat (6) @(negedge sys_clk);
        chk("pending", 16'h0000, pending);
      end
    join
    repeat (6) @(negedge sys_clk);
    chk("pending", 16'h0000, pending);
    $display("t_edge done");
  endtask : t_edge
  task automatic t_prio;
    internal_request = 16'h0201;
    @(negedge sys_clk);
    internal_request = 16'h0000;
    i_src.pulse(5'h16, 3);
    repeat (4) @(negedge sys_clk);
    chk("pending", 16'h02B1, pending);
    serve('{4'h0, 4'h4, 4'h5, 4'h7, 4'h9});
    chk("pending", 16'h0000, pending);
    $display("t_prio done");
  endtask : t_prio
  task automatic t_refuse;
    @(negedge sys_clk);
    service_start = 1'b1;
    @(negedge sys_clk);
    service_start = 1'b0;
    chk("idle ack", 16'h0, {15'h0, ack});
    i_src.pulse(5'h08, 2);
    repeat (5) @(negedge sys_clk);
    serve('{4'h6});
    $display("t_refuse done");
  endtask : t_refuse
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial begin
    reset = 1'b1;
    service_start = 1'b0;
    internal_request = 16'h0000;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    t_edge();
    t_prio();
    t_refuse();
    finish_test();
  end
  initial begin
    #5000;
    n_errors++;
    finish_test();
  end
endmodule : tb_top
